// >>> rtl/simd_addsub_horizontal_dup_unit.sv
// packed fp alternating add/sub, horizontal add/sub and lane duplicate unit
// requests come from decode each cycle; result returns two cycles later
`timescale 1ns/1ps

// Functional notes
// [RULE_01] single alternating: lanes 1,3 add, 0,2 subtract
// [RULE_02] double alternating: high adds, low subtracts
// [RULE_03] horizontal single sum of adjacent pairs
// [RULE_04] horizontal single difference of adjacent pairs
// [RULE_05] horizontal double sum per operand
// [RULE_06] horizontal double difference per operand
// [RULE_07] odd lanes duplicated downward into pairs
// [RULE_08] even lanes duplicated upward into pairs
// [RULE_09] low 64 bits copied to both halves
// [RULE_10] element zero is least significant lane
module simd_addsub_horizontal_dup_unit (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire simd_fp_pkg::simd_req_t req_i,
  output simd_fp_pkg::simd_rsp_t rsp_o
);
  import simd_fp_pkg::*;

  typedef enum logic [1:0] {
    sel_single,
    sel_double,
    sel_move,
    sel_none
  } res_sel_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    res_sel_t sel;
    logic [SP_LANES-1:0][SP_W-1:0] sp_x;
    logic [SP_LANES-1:0][SP_W-1:0] sp_y;
    logic [SP_LANES-1:0] sp_sub;
    logic [DP_LANES-1:0][DP_W-1:0] dp_x;
    logic [DP_LANES-1:0][DP_W-1:0] dp_y;
    logic [DP_LANES-1:0] dp_sub;
    logic [VEC_W-1:0] move;
  } stage_t;

  // [RULE_10] lowest lane first
  function automatic logic [SP_W-1:0] el32(input logic [VEC_W-1:0] v, input int i);
    el32 = v[SP_W*i +: SP_W];
  endfunction

  function automatic logic [DP_W-1:0] el64(input logic [VEC_W-1:0] v, input int i);
    el64 = v[DP_W*i +: DP_W];
  endfunction

  // element k fills lanes 0 and 1, element k+2 lanes 2 and 3
  function automatic logic [VEC_W-1:0] dup32(input logic [VEC_W-1:0] v, input int k);
    dup32 = {el32(v, k + 2), el32(v, k + 2), el32(v, k), el32(v, k)};
  endfunction

  // result path of each op; codes outside the list find none
  function automatic res_sel_t op_sel(input simd_op_t op);
    unique case (op)
      alt_add_sub_single, horiz_sum_single, horiz_diff_single: begin
        op_sel = sel_single;
      end
      alt_add_sub_double, horiz_sum_double, horiz_diff_double: begin
        op_sel = sel_double;
      end
      odd_lane_duplicate_move, even_lane_duplicate_move, double_element_duplicate_move: begin
        op_sel = sel_move;
      end
      default: begin
        op_sel = sel_none;
      end
    endcase
  endfunction

  // horizontal difference ops run every lane as a subtraction
  function automatic logic is_diff(input simd_op_t op);
    is_diff = (op == horiz_diff_single) || (op == horiz_diff_double);
  endfunction

  // result of the lane group that the op was steered to
  function automatic logic [VEC_W-1:0] pick(input res_sel_t sel,
      input logic [VEC_W-1:0] sp, input logic [VEC_W-1:0] dp, input logic [VEC_W-1:0] mv);
    unique case (sel)
      sel_single: begin
        pick = sp;
      end
      sel_double: begin
        pick = dp;
      end
      sel_move: begin
        pick = mv;
      end
      sel_none: begin
        pick = VEC_RESET;
      end
    endcase
  endfunction

  stage_t st_d, st_q;
  simd_rsp_t rsp_d, rsp_q;
  logic [SP_LANES-1:0][SP_W-1:0] sp_res;
  logic [DP_LANES-1:0][DP_W-1:0] dp_res;

  // stage one: steer operands onto the lane adders
  always_comb begin
    st_d = '0;
    st_d.valid = req_i.valid;
    st_d.sel = op_sel(req_i.op);
    // undefined op codes complete with a zero result and a flag
    st_d.illegal = req_i.valid && (op_sel(req_i.op) == sel_none);
    unique case (req_i.op)
      alt_add_sub_single: begin
        // [RULE_01] even lanes subtract
        for (int i = 0; i < SP_LANES; i++) begin
          st_d.sp_x[i] = el32(req_i.dst, i);
          st_d.sp_y[i] = el32(req_i.src, i);
          st_d.sp_sub[i] = (i % 2 == 0);
        end
      end
      alt_add_sub_double: begin
        // [RULE_02] low subtract, high add
        for (int j = 0; j < DP_LANES; j++) begin
          st_d.dp_x[j] = el64(req_i.dst, j);
          st_d.dp_y[j] = el64(req_i.src, j);
        end
        st_d.dp_sub = 2'b01;
      end
      horiz_sum_single, horiz_diff_single: begin
        // [RULE_03] [RULE_04] pairs from dst then src
        for (int i = 0; i < SP_LANES / 2; i++) begin
          st_d.sp_x[i] = el32(req_i.dst, 2 * i);
          st_d.sp_y[i] = el32(req_i.dst, 2 * i + 1);
          st_d.sp_x[i+2] = el32(req_i.src, 2 * i);
          st_d.sp_y[i+2] = el32(req_i.src, 2 * i + 1);
        end
        st_d.sp_sub = {SP_LANES{is_diff(req_i.op)}};
      end
      horiz_sum_double, horiz_diff_double: begin
        // [RULE_05] [RULE_06] low from dst, high from src
        st_d.dp_x[0] = el64(req_i.dst, 0);
        st_d.dp_y[0] = el64(req_i.dst, 1);
        st_d.dp_x[1] = el64(req_i.src, 0);
        st_d.dp_y[1] = el64(req_i.src, 1);
        st_d.dp_sub = {DP_LANES{is_diff(req_i.op)}};
      end
      odd_lane_duplicate_move: begin
        // [RULE_07] elements 1 and 3 doubled
        st_d.move = dup32(req_i.src, 1);
      end
      even_lane_duplicate_move: begin
        // [RULE_08] elements 0 and 2 doubled
        st_d.move = dup32(req_i.src, 0);
      end
      double_element_duplicate_move: begin
        // [RULE_09] low quadword in both halves
        st_d.move = {el64(req_i.src, 0), el64(req_i.src, 0)};
      end
      default: begin
        // nothing to steer; flag raised above
        st_d.move = VEC_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // four single lanes and two double lanes; idle lanes still toggle
  // on stale operands, traded for no extra gating in the datapath
  for (genvar g = 0; g < SP_LANES; g++) begin : g_sp
    fp_addsub #(
      .EW(SP_EW),
      .MW(SP_MW)
    ) u_sp (
      .a_i(st_q.sp_x[g]),
      .b_i(st_q.sp_y[g]),
      .sub_i(st_q.sp_sub[g]),
      .res_o(sp_res[g])
    );
  end

  for (genvar g = 0; g < DP_LANES; g++) begin : g_dp
    fp_addsub #(
      .EW(DP_EW),
      .MW(DP_MW)
    ) u_dp (
      .a_i(st_q.dp_x[g]),
      .b_i(st_q.dp_y[g]),
      .sub_i(st_q.dp_sub[g]),
      .res_o(dp_res[g])
    );
  end

  // stage two: pick the result for the destination register
  always_comb begin
    rsp_d.valid = st_q.valid;
    rsp_d.illegal = st_q.illegal;
    // idle cycles still steer stale operands through the lanes; zero
    // them here so nothing old can look like a fresh result
    if (st_q.valid) begin
      rsp_d.data = pick(st_q.sel, sp_res, dp_res, st_q.move);
    end else begin
      rsp_d.data = VEC_RESET;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_o = rsp_q;

endmodule

// >>> rtl/simd_fp_pkg.sv
// shared types and constants of the packed add/sub/duplicate unit
// assumes one core clock; requests arrive already decoded
package simd_fp_pkg;

  localparam int VEC_W = 128;
  localparam int SP_W = 32;
  localparam int DP_W = 64;
  localparam int SP_EW = 8;
  localparam int SP_MW = 23;
  localparam int DP_EW = 11;
  localparam int DP_MW = 52;
  localparam int SP_LANES = VEC_W / SP_W;
  localparam int DP_LANES = VEC_W / DP_W;
  // cycles from an accepted request to its result
  localparam int PIPE_LATENCY = 2;
  localparam logic [VEC_W-1:0] VEC_RESET = 128'h0;

  typedef enum logic [3:0] {
    alt_add_sub_single,
    alt_add_sub_double,
    horiz_sum_single,
    horiz_diff_single,
    horiz_sum_double,
    horiz_diff_double,
    odd_lane_duplicate_move,
    even_lane_duplicate_move,
    double_element_duplicate_move
  } simd_op_t;

  typedef struct packed {
    logic valid;
    simd_op_t op;
    logic [VEC_W-1:0] dst;
    logic [VEC_W-1:0] src;
  } simd_req_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic [VEC_W-1:0] data;
  } simd_rsp_t;

endpackage

// >>> rtl/fp_addsub.sv
// binary floating-point adder/subtractor, one format per instance
// purely combinational; caller registers around it
`timescale 1ns/1ps
module fp_addsub #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  input wire logic [EW+MW:0] a_i,
  input wire logic [EW+MW:0] b_i,
  input wire logic sub_i,
  output logic [EW+MW:0] res_o
);
  localparam int W = EW + MW + 1;
  localparam int X = MW + 4;
  localparam logic [EW:0] EMAX = {1'b0, {EW{1'b1}}};
  localparam logic [EW:0] EONE = {{EW{1'b0}}, 1'b1};

  logic sa, sb, sx, sy, a_nan, b_nan, a_inf, b_inf, inc, rs;
  logic [EW-1:0] ea, eb;
  logic [EW:0] ex, ey, d, e;
  logic [MW-1:0] fx, fy;
  logic [X-1:0] mx, my, ysh, m, lost;
  logic [X:0] s;
  logic [MW+1:0] mr;

  always_comb begin
    sa = a_i[W-1];
    sb = b_i[W-1] ^ sub_i;
    ea = a_i[W-2:MW];
    eb = b_i[W-2:MW];
    a_nan = (&ea) & (|a_i[MW-1:0]);
    b_nan = (&eb) & (|b_i[MW-1:0]);
    a_inf = (&ea) & ~(|a_i[MW-1:0]);
    b_inf = (&eb) & ~(|b_i[MW-1:0]);
    // larger magnitude goes first so the difference never goes negative
    if (a_i[W-2:0] >= b_i[W-2:0]) begin
      sx = sa;
      sy = sb;
      ex = {1'b0, ea};
      ey = {1'b0, eb};
      fx = a_i[MW-1:0];
      fy = b_i[MW-1:0];
    end else begin
      sx = sb;
      sy = sa;
      ex = {1'b0, eb};
      ey = {1'b0, ea};
      fx = b_i[MW-1:0];
      fy = a_i[MW-1:0];
    end
    mx = {|ex, fx, 3'b000};
    my = {|ey, fy, 3'b000};
    // subnormals share the exponent of the smallest normal
    if (ex == '0) ex = EONE;
    if (ey == '0) ey = EONE;
    d = ex - ey;
    lost = '0;
    if (d >= (EW+1)'(X)) begin
      ysh = '0;
      ysh[0] = |my;
    end else begin
      ysh = my >> d;
      lost = my & ~({X{1'b1}} << d);
      ysh[0] = ysh[0] | (|lost);
    end
    if (sx ^ sy) begin
      s = {1'b0, mx} - {1'b0, ysh};
    end else begin
      s = {1'b0, mx} + {1'b0, ysh};
    end
    e = ex;
    if (s[X]) begin
      m = s[X:1];
      m[0] = m[0] | s[0];
      e = e + EONE;
    end else begin
      m = s[X-1:0];
      for (int i = 0; i < X; i++) begin
        if (!m[X-1] && e > EONE) begin
          m = m << 1;
          e = e - EONE;
        end
      end
      if (!m[X-1]) e = '0;
    end
    // round to nearest, ties to even
    inc = m[2] & (m[1] | m[0] | m[3]);
    mr = {1'b0, m[X-1:3]} + (MW+2)'(inc);
    if (mr[MW+1]) begin
      mr = mr >> 1;
      e = e + EONE;
    end else if (e == '0 && mr[MW]) begin
      e = EONE;
    end
    // exact cancellation gives +0
    rs = (s == '0 && (sx ^ sy)) ? 1'b0 : sx;
    if (e >= EMAX) res_o = {rs, {EW{1'b1}}, {MW{1'b0}}};
    else res_o = {rs, e[EW-1:0], mr[MW-1:0]};
    if (a_nan) res_o = a_i | (W'(1) << (MW-1));
    else if (b_nan) res_o = b_i | (W'(1) << (MW-1));
    else if (a_inf && b_inf && (sa ^ sb)) res_o = {1'b1, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
    else if (a_inf) res_o = a_i;
    else if (b_inf) res_o = {sb, b_i[W-2:0]};
  end
endmodule

// >>> verification/simd_unit_asserts.sv
// checker of response timing, flags and the duplicate moves
// sees only the unit's ports; bound below
`timescale 1ns/1ps
module simd_unit_asserts
  import simd_fp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire simd_fp_pkg::simd_req_t req_i,
  input wire simd_fp_pkg::simd_rsp_t rsp_o
);
  simd_req_t s1_q;
  simd_req_t s2_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= req_i;
      s2_q <= s1_q;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence issue_s;
    req_i.valid;
  endsequence
  sequence done_s(simd_op_t o);
    rsp_o.valid && s2_q.op == o;
  endsequence
  resp_latency_a: assert property (issue_s |-> ##2 rsp_o.valid)
    else $error("no response two edges after a request");
  no_ghost_a: assert property (rsp_o.valid |-> s2_q.valid)
    else $error("response without a request");
  odd_dup_a: assert property (done_s(odd_lane_duplicate_move)
    |-> rsp_o.data == {{2{s2_q.src[127:96]}}, {2{s2_q.src[63:32]}}}) else $error("odd dup");
  even_dup_a: assert property (done_s(even_lane_duplicate_move)
    |-> rsp_o.data == {{2{s2_q.src[95:64]}}, {2{s2_q.src[31:0]}}}) else $error("even dup");
  dbl_dup_a: assert property (done_s(double_element_duplicate_move)
    |-> rsp_o.data == {2{s2_q.src[63:0]}}) else $error("double dup");
  legal_op_a: assert property (rsp_o.valid && s2_q.op < 4'h9 |-> !rsp_o.illegal)
    else $error("legal op flagged");
  bad_op_a: assert property (issue_s ##0 req_i.op > 4'h8
    |-> ##2 rsp_o.illegal && rsp_o.data == '0) else $error("bad op not flagged");
  idle_zero_a: assert property (!rsp_o.valid |-> rsp_o.data == '0)
    else $error("data without response");
endmodule

bind simd_addsub_horizontal_dup_unit simd_unit_asserts u_chk (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .req_i(req_i),
  .rsp_o(rsp_o)
);

// >>> verification/decode_model.sv
// decode and register file stand-in feeding the request port
// assumes the bench changes its inputs at falling edges
`timescale 1ns/1ps
module decode_model
  import simd_fp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic issue_i,
  input wire simd_fp_pkg::simd_op_t op_i,
  input wire logic [127:0] dst_i,
  input wire logic [127:0] src_i,
  output simd_fp_pkg::simd_req_t req_o
);
  logic [255:0] last_q = '0;
  always_ff @(posedge ref_clk_i) begin
    if (issue_i) begin
      last_q <= {dst_i, src_i};
    end
  end
  // idle cycles carry inverted operands so nothing stale can match
  always_comb begin
    req_o = {issue_i, op_i, issue_i ? {dst_i, src_i} : ~last_q};
  end
endmodule

// >>> verification/testbench.sv
// self-checking bench of the packed fp add/sub/duplicate unit
// operands are small integers, so every result is exact
`timescale 1ns/1ps
module testbench;
  import simd_fp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic issue = 1'b0;
  simd_op_t op = alt_add_sub_single;
  logic [127:0] dst = '0;
  logic [127:0] src = '0;
  logic [127:0] a_s, b_s, a_d, b_d;
  simd_req_t req;
  simd_rsp_t rsp;
  int mismatches = 0;
  int n_compared = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  decode_model dm (.ref_clk_i(ref_clk_i), .issue_i(issue), .op_i(op), .dst_i(dst),
    .src_i(src), .req_o(req));
  simd_addsub_horizontal_dup_unit uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req),
    .rsp_o(rsp));
  function automatic logic [31:0] f32(input real r);
    logic [63:0] d;
    logic [10:0] e;
    d = $realtobits(r);
    e = d[62:52] - 11'h380;
    if (d[62:0] == 63'h0) return {d[63], 31'h0};
    return {d[63], e[7:0], d[51:29]};
  endfunction
  function automatic logic [127:0] sp4(input real a, b, c, d);
    return {f32(d), f32(c), f32(b), f32(a)};
  endfunction
  function automatic logic [127:0] dp2(input real a, b);
    return {$realtobits(b), $realtobits(a)};
  endfunction
  task automatic cmp(input logic [129:0] got, input logic [129:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input simd_op_t o, input logic [127:0] a, b, x, input logic bad);
    @(negedge ref_clk_i);
    op = o;
    dst = a;
    src = b;
    issue = 1'b1;
    @(negedge ref_clk_i);
    issue = 1'b0;
    @(negedge ref_clk_i);
    cmp(rsp, {1'b1, bad, x});
  endtask
  task automatic t_alt();
    run(alt_add_sub_single, a_s, b_s, sp4(-7, 6, -3, 21), 1'b0);
    run(alt_add_sub_double, a_d, b_d, dp2(-6, 5), 1'b0);
    run(simd_op_t'(4'hF), a_s, b_s, '0, 1'b1);
  endtask
  task automatic t_horiz();
    run(horiz_sum_single, a_s, b_s, sp4(3, 8, 12, 22), 1'b0);
    run(horiz_diff_single, a_s, b_s, sp4(-1, -2, 4, -10), 1'b0);
    run(horiz_sum_double, a_d, b_d, dp2(4, 11), 1'b0);
    run(horiz_diff_double, a_d, b_d, dp2(0, 5), 1'b0);
  endtask
  task automatic t_dup();
    run(odd_lane_duplicate_move, a_s, b_s, sp4(4, 4, 16, 16), 1'b0);
    run(even_lane_duplicate_move, a_s, b_s, sp4(8, 8, 6, 6), 1'b0);
    run(double_element_duplicate_move, a_s, b_s, {2{b_s[63:0]}}, 1'b0);
  endtask
  // back-to-back requests return in order, then idle
  task automatic t_b2b();
    @(negedge ref_clk_i);
    issue = 1'b1;
    dst = a_s;
    src = b_s;
    op = horiz_sum_single;
    @(negedge ref_clk_i);
    op = even_lane_duplicate_move;
    @(negedge ref_clk_i);
    issue = 1'b0;
    cmp(rsp, {2'b10, sp4(3, 8, 12, 22)});
    @(negedge ref_clk_i);
    cmp(rsp, {2'b10, sp4(8, 8, 6, 6)});
    @(negedge ref_clk_i);
    cmp(rsp, 130'h0);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    a_s = sp4(1, 2, 3, 5);
    b_s = sp4(8, 4, 6, 16);
    a_d = dp2(2, 2);
    b_d = dp2(8, 3);
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_alt();
    t_horiz();
    t_dup();
    t_b2b();
    print_verdict();
  end
  // about 37 cycles of traffic; far more means a hang
  initial begin
    repeat (400) @(posedge ref_clk_i);
    mismatches++;
    print_verdict();
  end
endmodule
